/* include/msw_regs.vh */
`ifndef MSW_REGS_VH
`define MSW_REGS_VH
// ==========================================
// Register byte offsets
`define MSW_OFF_PROTECT 12'h000
`define MSW_OFF_MSTP_A 12'h010
`define MSW_OFF_MSTP_B 12'h014
`define MSW_OFF_MSTP_C 12'h018
`define MSW_OFF_MSTP_D 12'h01C
`define MSW_OFF_CLK_CTRL 12'h020
`define MSW_OFF_MODE_CTRL 12'h024
`define MSW_OFF_SWRESET 12'h028
`define MSW_OFF_LVD_CTRL 12'h02C
`define MSW_OFF_LP_CTRL 12'h030
`define MSW_OFF_IRQ_STAT 12'h034
`define MSW_OFF_IRQ_MASK 12'h038
`define MSW_OFF_MOD_STATE 12'h03C
// ==========================================
// Protect register fields
`define MSW_PRC_CLK 0
`define MSW_PRC_MODE 1
`define MSW_PRC_LVD 3
// ==========================================
// Module stop bit positions
`define MSW_BIT_PWM 7
`define MSW_BIT_NET0 15
`define MSW_BIT_SPI1 16
`define MSW_BIT_I2C1 20
`define MSW_BIT_SPI2 22
`define MSW_BIT_DRAW 28
`define MSW_BIT_DISP 29
`define MSW_BIT_SND1 14
`define MSW_BIT_SND0 15
`define MSW_BIT_SEC 27
// ==========================================
// Reset values: all stop bits set, protection closed
`define MSW_RST_MSTP 32'hFFFFFFFF
`define MSW_RST_ZERO 32'h00000000
`define MSW_SWRESET_KEY 16'hA501
// ==========================================
// Interrupt status bits
`define MSW_IRQ_PODIS 0
`define MSW_IRQ_WAKE 1
// Low-power control: bit0 all-module clock stop, bit1 deep (undefined) mode
`define MSW_LP_ALLSTOP 0
`define MSW_LP_DEEP 1
`define MSW_NMOD 14
`endif

/* core/msw_clk_gate.v */
`timescale 1ns/100ps
// ==========================================
// Per-module clock gate and retained or powered-down state
module msw_clk_gate #(
    parameter N = 14
) (
    clk,
    rst_n,
    stop,
    deep,
    clk_en,
    pwr_on,
    state_valid
);
    input wire clk;
    input wire rst_n;
    input wire [N-1:0] stop;
    input wire deep;
    output reg [N-1:0] clk_en;
    output reg [N-1:0] pwr_on;
    output reg [N-1:0] state_valid;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_en <= {N{1'b0}};
            pwr_on <= {N{1'b1}};
            state_valid <= {N{1'b0}};
        end else begin
            clk_en <= ~stop;
            // Stopped and retained keeps power so the module's registers hold
            pwr_on <= ~(stop & {N{deep}});
            // Once power is removed, contents are undefined until the module's clock restarts; reset also marks them invalid
            state_valid <= (state_valid | ~stop) & ~(stop & {N{deep}});
        end
    end
endmodule // msw_clk_gate

/* core/msw_top.v */
`timescale 1ns/100ps
`include "msw_regs.vh"
module msw_top (
    CLK_SYS,
    RESETN,
    PSEL,
    PENABLE,
    PWRITE,
    PADDR,
    PWDATA,
    PRDATA,
    PREADY,
    PSLVERR,
    PODIS_EVENT,
    WAKE_EVENT,
    PODIS_IRQ_EN,
    MOD_CLK_EN,
    MOD_PWR_ON,
    CLK_CTRL,
    MODE_CTRL,
    LVD_CTRL,
    SW_RESET,
    ALL_STOP,
    IRQ
);
    input wire CLK_SYS;
    input wire RESETN;
    input wire PSEL;
    input wire PENABLE;
    input wire PWRITE;
    input wire [11:0] PADDR;
    input wire [31:0] PWDATA;
    output reg [31:0] PRDATA;
    output wire PREADY;
    output wire PSLVERR;
    input wire PODIS_EVENT;
    input wire WAKE_EVENT;
    input wire PODIS_IRQ_EN;
    output wire [`MSW_NMOD-1:0] MOD_CLK_EN;
    output wire [`MSW_NMOD-1:0] MOD_PWR_ON;
    output wire [31:0] CLK_CTRL;
    output wire [31:0] MODE_CTRL;
    output wire [31:0] LVD_CTRL;
    output reg SW_RESET;
    output wire ALL_STOP;
    output wire IRQ;

    // ==========================================
    // Reset release and pin synchronisers
    reg [1:0] rst_sync_q;
    wire rst_n;
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Pins are asynchronous to CLK_SYS; only the second stage is read by logic
    reg [2:0] meta_q;
    reg [2:0] sync_q;
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 3'b000;
            sync_q <= 3'b000;
        end else begin
            meta_q <= {PODIS_IRQ_EN, WAKE_EVENT, PODIS_EVENT};
            sync_q <= meta_q;
        end
    end
    wire podis_ev = sync_q[0];
    wire wake_ev = sync_q[1];
    wire podis_en = sync_q[2];

    // ==========================================
    // Registers
    reg [31:0] prot_q;
    reg [31:0] mstp_a_q;
    reg [31:0] mstp_b_q;
    reg [31:0] mstp_c_q;
    reg [31:0] mstp_d_q;
    reg [31:0] clk_ctrl_q;
    reg [31:0] mode_ctrl_q;
    reg [31:0] lvd_ctrl_q;
    reg [31:0] lp_ctrl_q;
    reg [1:0] irq_stat_q;
    reg [1:0] irq_mask_q;
    reg podis_pend_q;

    wire wr = PSEL & PENABLE & PWRITE;
    wire clk_ok = prot_q[`MSW_PRC_CLK];
    wire mode_ok = prot_q[`MSW_PRC_MODE];
    wire lvd_ok = prot_q[`MSW_PRC_LVD];

    function hit;
        input [11:0] a;
        input [11:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    wire known = hit(PADDR, `MSW_OFF_PROTECT) | hit(PADDR, `MSW_OFF_MSTP_A)
        | hit(PADDR, `MSW_OFF_MSTP_B) | hit(PADDR, `MSW_OFF_MSTP_C)
        | hit(PADDR, `MSW_OFF_MSTP_D) | hit(PADDR, `MSW_OFF_CLK_CTRL)
        | hit(PADDR, `MSW_OFF_MODE_CTRL) | hit(PADDR, `MSW_OFF_SWRESET)
        | hit(PADDR, `MSW_OFF_LVD_CTRL) | hit(PADDR, `MSW_OFF_LP_CTRL)
        | hit(PADDR, `MSW_OFF_IRQ_STAT) | hit(PADDR, `MSW_OFF_IRQ_MASK)
        | hit(PADDR, `MSW_OFF_MOD_STATE);

    assign PREADY = 1'b1;
    // Unmapped addresses answer with an error; protected writes are silently dropped
    assign PSLVERR = PSEL & PENABLE & ~known;

    wire all_stop = lp_ctrl_q[`MSW_LP_ALLSTOP];
    wire deep = lp_ctrl_q[`MSW_LP_DEEP];

    // ==========================================
    // Write strobes, each already qualified by its protect group except the protect and mask writes
    wire wr_prot = wr & hit(PADDR, `MSW_OFF_PROTECT);
    wire wr_clk = wr & hit(PADDR, `MSW_OFF_CLK_CTRL) & clk_ok;
    wire wr_mstp_a = wr & hit(PADDR, `MSW_OFF_MSTP_A) & mode_ok;
    wire wr_mstp_b = wr & hit(PADDR, `MSW_OFF_MSTP_B) & mode_ok;
    wire wr_mstp_c = wr & hit(PADDR, `MSW_OFF_MSTP_C) & mode_ok;
    wire wr_mstp_d = wr & hit(PADDR, `MSW_OFF_MSTP_D) & mode_ok;
    wire wr_mode = wr & hit(PADDR, `MSW_OFF_MODE_CTRL) & mode_ok;
    wire wr_lp = wr & hit(PADDR, `MSW_OFF_LP_CTRL) & mode_ok;
    // A wrong key is dropped as quietly as a locked write
    wire key_ok = (PWDATA[15:0] == `MSW_SWRESET_KEY);
    wire wr_swrst = wr & hit(PADDR, `MSW_OFF_SWRESET) & mode_ok & key_ok;
    wire wr_lvd = wr & hit(PADDR, `MSW_OFF_LVD_CTRL) & lvd_ok;
    wire wr_mask = wr & hit(PADDR, `MSW_OFF_IRQ_MASK);
    // Of the two event pins only the wake pin ends all-module stop; a port disable event stays flagged
    wire wake_exit = all_stop & wake_ev;

    // ==========================================
    // Protect register: only bits 0, 1 and 3 exist
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            prot_q <= `MSW_RST_ZERO;
        end else if (wr_prot) begin
            prot_q <= {28'h0000000, PWDATA[3], 1'b0, PWDATA[1:0]};
        end
    end

    // ==========================================
    // Clock generation group
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            clk_ctrl_q <= `MSW_RST_ZERO;
        end else if (wr_clk) begin
            clk_ctrl_q <= PWDATA;
        end
    end

    // ==========================================
    // Module stop registers; reset leaves every module stopped
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            mstp_a_q <= `MSW_RST_MSTP;
            mstp_b_q <= `MSW_RST_MSTP;
            mstp_c_q <= `MSW_RST_MSTP;
            mstp_d_q <= `MSW_RST_MSTP;
        end else begin
            if (wr_mstp_a) begin
                mstp_a_q <= PWDATA;
            end
            if (wr_mstp_b) begin
                mstp_b_q <= PWDATA;
            end
            if (wr_mstp_c) begin
                mstp_c_q <= PWDATA;
            end
            if (wr_mstp_d) begin
                mstp_d_q <= PWDATA;
            end
        end
    end

    // ==========================================
    // Operating mode and low-power control
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            mode_ctrl_q <= `MSW_RST_ZERO;
            lp_ctrl_q <= `MSW_RST_ZERO;
        end else begin
            if (wr_mode) begin
                mode_ctrl_q <= PWDATA;
            end
            if (wr_lp) begin
                lp_ctrl_q <= {30'h00000000, PWDATA[1:0]};
            end
            // A wake in the same cycle as a software write still ends the stop
            if (wake_exit) begin
                lp_ctrl_q[`MSW_LP_ALLSTOP] <= 1'b0;
            end
        end
    end

    // ==========================================
    // Software reset: a single-cycle pulse per accepted keyed write
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            SW_RESET <= 1'b0;
        end else begin
            SW_RESET <= wr_swrst;
        end
    end

    // ==========================================
    // Voltage detection group
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            lvd_ctrl_q <= `MSW_RST_ZERO;
        end else if (wr_lvd) begin
            lvd_ctrl_q <= PWDATA;
        end
    end

    // ==========================================
    // Interrupt mask, never protected
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_q <= 2'h0;
        end else if (wr_mask) begin
            irq_mask_q <= PWDATA[1:0];
        end
    end

    // ==========================================
    // Interrupt status: set wins over write-one-to-clear
    wire w1c = wr & hit(PADDR, `MSW_OFF_IRQ_STAT);
    wire [1:0] irq_clr = {2{w1c}} & PWDATA[1:0];
    // Port disable events are ignored while the port disable interrupt is not enabled
    wire podis_take = podis_ev & podis_en;
    wire podis_fire = podis_pend_q & ~all_stop;
    wire [1:0] irq_set = {wake_exit, podis_fire};
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= 2'h0;
            podis_pend_q <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
            // Event held while clocks are stopped; released once all-module stop ends, by a wake or a software write
            if (podis_take) begin
                podis_pend_q <= 1'b1;
            end else if (podis_fire) begin
                podis_pend_q <= 1'b0;
            end
        end
    end
    assign IRQ = |(irq_stat_q & irq_mask_q);
    assign ALL_STOP = all_stop;

    // ==========================================
    // Module stop vector; one bit can cover several modules
    // Order: pwm, podis, net, net_dma, phy_mgmt, spi1, i2c1, spi2, draw, disp, snd0, snd1, sec, rsvd
    wire pwm_timer_stop_bit = mstp_a_q[`MSW_BIT_PWM];
    wire net0_stop_bit = mstp_b_q[`MSW_BIT_NET0];
    wire spi1_stop_bit = mstp_b_q[`MSW_BIT_SPI1];
    wire i2c1_stop_bit = mstp_b_q[`MSW_BIT_I2C1];
    wire spi2_stop_bit = mstp_c_q[`MSW_BIT_SPI2];
    wire drawing_engine_stop_bit = mstp_c_q[`MSW_BIT_DRAW];
    wire display_ctrl_stop_bit = mstp_c_q[`MSW_BIT_DISP];
    wire sound0_stop_bit = mstp_d_q[`MSW_BIT_SND0];
    wire sound1_stop_bit = mstp_d_q[`MSW_BIT_SND1];
    wire secure_ip_stop_bit = mstp_d_q[`MSW_BIT_SEC];
    // All-module clock stop gates every module on top of its own bit
    wire [`MSW_NMOD-1:0] stop_vec = {`MSW_NMOD{all_stop}} | {
        1'b1,
        secure_ip_stop_bit,
        sound1_stop_bit, sound0_stop_bit,
        display_ctrl_stop_bit, drawing_engine_stop_bit,
        spi2_stop_bit, i2c1_stop_bit, spi1_stop_bit,
        {3{net0_stop_bit}},
        {2{pwm_timer_stop_bit}}
    };

    wire [`MSW_NMOD-1:0] state_valid;
    msw_clk_gate #(
        .N(`MSW_NMOD)
    ) u_gate (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .stop(stop_vec),
        .deep(deep),
        .clk_en(MOD_CLK_EN),
        .pwr_on(MOD_PWR_ON),
        .state_valid(state_valid)
    );

    assign CLK_CTRL = clk_ctrl_q;
    assign MODE_CTRL = mode_ctrl_q;
    assign LVD_CTRL = lvd_ctrl_q;

    // ==========================================
    // Read mux; data is captured in the setup cycle so it stands through the access
    wire [31:0] mod_state = {2'h0, state_valid, 2'h0, MOD_CLK_EN};
    reg [31:0] prdata_d;
    always @* begin
        prdata_d = 32'h00000000;
        case (1'b1)
            hit(PADDR, `MSW_OFF_PROTECT): prdata_d = prot_q;
            hit(PADDR, `MSW_OFF_MSTP_A): prdata_d = mstp_a_q;
            hit(PADDR, `MSW_OFF_MSTP_B): prdata_d = mstp_b_q;
            hit(PADDR, `MSW_OFF_MSTP_C): prdata_d = mstp_c_q;
            hit(PADDR, `MSW_OFF_MSTP_D): prdata_d = mstp_d_q;
            hit(PADDR, `MSW_OFF_CLK_CTRL): prdata_d = clk_ctrl_q;
            hit(PADDR, `MSW_OFF_MODE_CTRL): prdata_d = mode_ctrl_q;
            hit(PADDR, `MSW_OFF_SWRESET): prdata_d = 32'h00000000;
            hit(PADDR, `MSW_OFF_LVD_CTRL): prdata_d = lvd_ctrl_q;
            hit(PADDR, `MSW_OFF_LP_CTRL): prdata_d = lp_ctrl_q;
            hit(PADDR, `MSW_OFF_IRQ_STAT): prdata_d = {30'h00000000, irq_stat_q};
            hit(PADDR, `MSW_OFF_IRQ_MASK): prdata_d = {30'h00000000, irq_mask_q};
            hit(PADDR, `MSW_OFF_MOD_STATE): prdata_d = mod_state;
            default: prdata_d = 32'h00000000;
        endcase
    end

    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            PRDATA <= 32'h00000000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= prdata_d;
        end
    end
endmodule // msw_top

/* bench/msw_props.sv */
`timescale 1ns/100ps
`include "msw_regs.vh"
// ==========================================
// Port-level properties
module msw_props (
    input wire CLK_SYS,
    input wire RESETN,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    input wire PSLVERR,
    input wire WAKE_EVENT,
    input wire [`MSW_NMOD-1:0] MOD_CLK_EN,
    input wire [31:0] CLK_CTRL,
    input wire [31:0] LVD_CTRL,
    input wire SW_RESET,
    input wire ALL_STOP
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    // Shadow of the protect register, rebuilt from observed writes
    logic [31:0] prot_q;
    wire wr = PSEL && PENABLE && PWRITE;
    wire mapped = PADDR == 12'h000 || (PADDR >= 12'h010 && PADDR <= 12'h03C && PADDR[1:0] == 2'h0);
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) prot_q <= 32'h0;
        else if (wr && PADDR == `MSW_OFF_PROTECT) prot_q <= PWDATA;
    end
    a_unmapped_err: assert property (PSEL && PENABLE |-> PSLVERR == !mapped)
        else $error("slave error does not match address map");
    a_unmapped_zero: assert property (PSEL && PENABLE && !PWRITE && !mapped |-> PRDATA == 32'h0)
        else $error("unmapped read returned data");
    a_pwm_start: assert property (wr && PADDR == `MSW_OFF_MSTP_A && prot_q[1] && !ALL_STOP
        && !PWDATA[7] |-> ##2 MOD_CLK_EN[1:0] == 2'h3) else $error("pwm pair not started together");
    a_net_stop: assert property (wr && PADDR == `MSW_OFF_MSTP_B && prot_q[1]
        && PWDATA[15] |-> ##2 MOD_CLK_EN[4:2] == 3'h0) else $error("network trio not stopped");
    a_stop_locked: assert property (wr && PADDR == `MSW_OFF_MSTP_B && !prot_q[1]
        |=> $stable(MOD_CLK_EN)) else $error("locked stop write took effect");
    a_clk_write: assert property (wr && PADDR == `MSW_OFF_CLK_CTRL && prot_q[0]
        |=> CLK_CTRL == $past(PWDATA)) else $error("clock control write lost");
    a_lvd_locked: assert property (wr && PADDR == `MSW_OFF_LVD_CTRL && !prot_q[3]
        |=> $stable(LVD_CTRL)) else $error("locked voltage write took effect");
    a_swrst_pulse: assert property (wr && PADDR == `MSW_OFF_SWRESET && prot_q[1]
        && PWDATA[15:0] == 16'hA501 |=> SW_RESET ##1 !SW_RESET) else $error("reset pulse wrong");
    a_allstop_hold: assert property (ALL_STOP && !WAKE_EVENT && !$past(WAKE_EVENT)
        && !$past(WAKE_EVENT, 2) && !(wr && PADDR == `MSW_OFF_LP_CTRL) |=> ALL_STOP)
        else $error("all-stop left without wake");
    a_wake_exit: assert property ($rose(WAKE_EVENT) ##1 WAKE_EVENT[*3] |-> ##2 !ALL_STOP)
        else $error("wake did not end all-stop");
endmodule // msw_props

bind msw_top msw_props u_props (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PSLVERR(PSLVERR), .WAKE_EVENT(WAKE_EVENT), .MOD_CLK_EN(MOD_CLK_EN),
    .CLK_CTRL(CLK_CTRL), .LVD_CTRL(LVD_CTRL), .SW_RESET(SW_RESET), .ALL_STOP(ALL_STOP));

/* bench/msw_top_bench.sv */
`timescale 1ns/100ps
`include "msw_regs.vh"
module msw_top_bench;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic podis = 1'b0, wake = 1'b0, podis_en = 1'b0, serr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdata, v, sh[3], m[4];
    logic [11:0] offs[3] = '{`MSW_OFF_CLK_CTRL, `MSW_OFF_MODE_CTRL, `MSW_OFF_LVD_CTRL};
    logic [31:0] pv[4] = '{32'h0, 32'h1, 32'h2, 32'h8};
    int gb[3] = '{0, 1, 3};
    wire [31:0] prdata, clk_ctrl, mode_ctrl, lvd_ctrl;
    wire [13:0] clk_en, pwr_on;
    wire pready, pslverr, sw_reset, all_stop, irq;
    int error_cnt = 0, cmp_count = 0, sw_cnt = 0;
    always #4 clk = ~clk;
    always @(posedge clk) if (sw_reset === 1'b1) sw_cnt++;
    msw_top dut_u (.CLK_SYS(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PODIS_EVENT(podis), .WAKE_EVENT(wake), .PODIS_IRQ_EN(podis_en),
        .MOD_CLK_EN(clk_en), .MOD_PWR_ON(pwr_on), .CLK_CTRL(clk_ctrl), .MODE_CTRL(mode_ctrl),
        .LVD_CTRL(lvd_ctrl), .SW_RESET(sw_reset), .ALL_STOP(all_stop), .IRQ(irq));
    task chk(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task test_done;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ==========================================
    // APB master; two idle edges let registered and gated outputs settle
    task apb(logic w, logic [11:0] a, logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdata = prdata; serr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
        @(posedge clk);
    endtask
    function logic [13:0] exp_en(logic [31:0] a, b, c, d);
        return {1'b0, ~d[27], ~d[14], ~d[15], ~c[29], ~c[28], ~c[22], ~b[20], ~b[16],
            {3{~b[15]}}, {2{~a[7]}}};
    endfunction
    initial begin
        void'($urandom(32'hB4028F20));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(0, `MSW_OFF_MSTP_A, 0); chk("mstp_a", 32'hFFFFFFFF, rdata);
        sh = '{32'h0, 32'h0, 32'h0};
        // ==========================================
        // Each protect bit opens only its own group
        for (int i = 0; i < 4; i++) begin
            apb(1, `MSW_OFF_PROTECT, pv[i]);
            for (int j = 0; j < 3; j++) begin
                v = $urandom; apb(1, offs[j], v);
                if (pv[i][gb[j]]) sh[j] = v;
            end
            chk("clk_ctrl", sh[0], clk_ctrl);
            chk("mode_ctrl", sh[1], mode_ctrl);
            chk("lvd_ctrl", sh[2], lvd_ctrl);
        end
        apb(1, `MSW_OFF_MSTP_B, 0); chk("clk_en", 0, clk_en);
        // ==========================================
        // Stop bit mapping: all clear, all set, then random
        apb(1, `MSW_OFF_PROTECT, 32'h2);
        for (int i = 0; i < 16; i++) begin
            for (int j = 0; j < 4; j++) begin
                m[j] = i < 2 ? {32{i[0]}} : $urandom;
                apb(1, `MSW_OFF_MSTP_A + 12'(4 * j), m[j]);
            end
            chk("clk_en", exp_en(m[0], m[1], m[2], m[3]), clk_en);
            apb(0, `MSW_OFF_MOD_STATE, 0); chk("state", exp_en(m[0], m[1], m[2], m[3]), rdata[13:0]);
        end
        apb(1, `MSW_OFF_LP_CTRL, 32'h2); chk("pwr_deep", exp_en(m[0], m[1], m[2], m[3]), pwr_on);
        apb(0, `MSW_OFF_MOD_STATE, 0);
        chk("lost_state", exp_en(m[0], m[1], m[2], m[3]), rdata[29:16]);
        apb(1, `MSW_OFF_LP_CTRL, 32'h0); chk("pwr_on", 14'h3FFF, pwr_on);
        // ==========================================
        // Port disable event held through all-module stop
        apb(1, `MSW_OFF_IRQ_MASK, 32'h1);
        podis <= 1'b1; repeat (3) @(posedge clk);
        podis <= 1'b0; repeat (4) @(posedge clk);
        chk("irq_dis", 0, irq);
        podis_en <= 1'b1;
        apb(1, `MSW_OFF_LP_CTRL, 32'h1); chk("all_stop", 1, all_stop);
        podis <= 1'b1; repeat (3) @(posedge clk);
        podis <= 1'b0; repeat (6) @(posedge clk);
        chk("all_stop", 1, all_stop); chk("irq", 0, irq);
        wake <= 1'b1; repeat (6) @(posedge clk);
        wake <= 1'b0; repeat (6) @(posedge clk);
        chk("all_stop", 0, all_stop); chk("irq", 1, irq);
        apb(0, `MSW_OFF_IRQ_STAT, 0); chk("stat", 1, rdata[0]);
        apb(1, `MSW_OFF_IRQ_MASK, 0); chk("irq_mask", 0, irq);
        apb(1, `MSW_OFF_IRQ_MASK, 1); chk("irq_unmask", 1, irq);
        apb(1, `MSW_OFF_IRQ_STAT, 1); chk("irq_clr", 0, irq);
        apb(0, 12'h004, 0); chk("slverr", 1, serr); chk("rd_unmapped", 0, rdata);
        // ==========================================
        // Software reset needs the mode group open
        apb(1, `MSW_OFF_PROTECT, 0); apb(1, `MSW_OFF_SWRESET, 32'hA501);
        chk("swrst_locked", 0, sw_cnt);
        apb(1, `MSW_OFF_PROTECT, 2); apb(1, `MSW_OFF_SWRESET, 32'hA501);
        chk("swrst", 1, sw_cnt);
        test_done;
    end
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        test_done;
    end
endmodule // msw_top_bench
